/* rtl/frwp_defs.vh */
`ifndef FRWP_DEFS_VH
`define FRWP_DEFS_VH
// register byte addresses (printed offsets)
`define FRWP_ADDR_BLOCK_CMP    16'hFFA6
`define FRWP_ADDR_END_CMP      16'hFFA7
`define FRWP_ADDR_PROG_BUF     16'hFFA8
// extra registers
`define FRWP_ADDR_CTRL         16'hFFAC
`define FRWP_ADDR_STATUS       16'hFFB0
`define FRWP_ADDR_PTR          16'hFFB4
// reset values
`define FRWP_RST_BYTE          8'h00
`define FRWP_RST_PROTECT       8'hFF
// protect byte location in flash
`define FRWP_PROTECT_ADDR      16'h0081
// field positions
`define FRWP_SEL_MSB           6
`define FRWP_SEL_LSB           2
`define FRWP_CTRL_SELF_BIT     0
`define FRWP_CTRL_START_BIT    1
`define FRWP_CTRL_LOAD_BIT     2
`define FRWP_STAT_WEPR_BIT     2
`define FRWP_STAT_BUSY_BIT     7
`endif

/* rtl/frwp_top.v */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "frwp_defs.vh"

module frwp_top #(
    parameter NBLK = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [15:0] flash_addr,
    output reg         flash_rd,
    input  wire [7:0]  flash_rdata,
    output reg         flash_step,
    output reg  [7:0]  flash_wdata
);

    localparam ST_IDLE = 2'b00;
    localparam ST_LOAD = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg  [7:0] block_compare_q;
    reg  [7:0] end_address_compare_q;
    reg  [7:0] program_byte_buffer_q;
    reg  [7:0] block_pointer_q;
    reg  [7:0] low_address_pointer_q;
    reg  [7:0] protect_byte_q;
    reg        self_mode_q;
    reg        busy_q;
    reg        wepr_err_q;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    wire       setup;
    wire       wr;
    wire       rd;
    wire [4:0] sel;
    wire       blk_prot;
    wire       start;
    wire       load;
    wire       at_end;
    wire [2:0] reg_idx;
    wire       hit_blk;
    wire       hit_end;
    wire       hit_buf;
    wire       hit_ctrl;
    wire       hit_stat;
    wire       hit_ptr;

    // number of protected low blocks, 0 means none; 32 protects all
    // only the block number is compared, so a wide sentinel covers
    // every variant without knowing its block count
    function [5:0] prot_count;
        input [4:0] code;
        begin
            if (code == 5'h1F) begin
                prot_count = 6'd0;
            end else if (NBLK == 4) begin
                if (code == 5'h0E) prot_count = 6'd4;
                else if (code == 5'h0F) prot_count = 6'd2;
                else prot_count = 6'd32;
            end else if (NBLK == 8) begin
                if (code >= 5'h0C && code <= 5'h0F)
                    prot_count = 6'd8 - {3'b000, code[1:0], 1'b0};
                else prot_count = 6'd32;
            end else begin
                if (code >= 5'h08 && code <= 5'h0F)
                    prot_count = 6'd16 - {2'b00, code[2:0], 1'b0};
                else prot_count = 6'd32;
            end
        end
    endfunction

    // byte-lane merge for whole-byte writes under one lane strobe
    function [7:0] lane_merge;
        input [7:0] old;
        input [7:0] nw;
        input       en;
        begin
            lane_merge = en ? nw : old;
        end
    endfunction

    // register index of a bus address, 0 for an unmapped address
    // shared by the error answer, the read mux and the control, status and pointer write strobes
    function [2:0] reg_index;
        input [15:0] a;
        begin
            if (a == `FRWP_ADDR_BLOCK_CMP) begin
                reg_index = 3'd1;
            end else if (a == `FRWP_ADDR_END_CMP) begin
                reg_index = 3'd2;
            end else if (a == `FRWP_ADDR_PROG_BUF) begin
                reg_index = 3'd3;
            end else if (a == `FRWP_ADDR_CTRL) begin
                reg_index = 3'd4;
            end else if (a == `FRWP_ADDR_STATUS) begin
                reg_index = 3'd5;
            end else if (a == `FRWP_ADDR_PTR) begin
                reg_index = 3'd6;
            end else begin
                reg_index = 3'd0;
            end
        end
    endfunction

    // one-hot register hits from the shared decode
    // paddr is held through setup and access, so one decode serves both
    assign reg_idx  = reg_index(paddr);
    assign hit_blk  = reg_idx == 3'd1;
    assign hit_end  = reg_idx == 3'd2;
    assign hit_buf  = reg_idx == 3'd3;
    assign hit_ctrl = reg_idx == 3'd4;
    assign hit_stat = reg_idx == 3'd5;
    assign hit_ptr  = reg_idx == 3'd6;

    // bus phase qualifiers and sequencer strobes
    // writes land only at the access edge with ready high
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite & pready;
    assign rd       = setup & ~pwrite;
    assign sel      = protect_byte_q[`FRWP_SEL_MSB:`FRWP_SEL_LSB];
    assign blk_prot = self_mode_q &&
                      ({2'b00, block_pointer_q[3:0]} < prot_count(sel));
    assign start    = wr && hit_ctrl && pwdata[`FRWP_CTRL_START_BIT];
    assign load     = wr && hit_ctrl && pwdata[`FRWP_CTRL_LOAD_BIT];
    assign at_end   = block_pointer_q == block_compare_q &&
                      low_address_pointer_q == end_address_compare_q;

    // apb handshake: no wait state, answer in access cycle
    // ready is a registered copy of setup, so it stands exactly one cycle
    // and back-to-back transfers need no idle cycle between them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && reg_idx == 3'd0;
        end
    end

    // read data mux
    // loaded at the setup edge so data stands while ready is high
    // unmapped reads return zero alongside the error answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            if (hit_blk) begin
                prdata <= {24'h000000, block_compare_q};
            end else if (hit_end) begin
                prdata <= {24'h000000, end_address_compare_q};
            end else if (hit_buf) begin
                prdata <= {24'h000000, program_byte_buffer_q};
            end else if (hit_ctrl) begin
                prdata <= {16'h0000, protect_byte_q, 7'h00, self_mode_q};
            end else if (hit_stat) begin
                prdata <= {24'h000000, busy_q, 4'h0, wepr_err_q, 2'b00};
            end else if (hit_ptr) begin
                prdata <= {16'h0000, block_pointer_q, low_address_pointer_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // software registers
    // lane 0 strobe gates the compare and buffer writes; a cleared strobe leaves
    // them untouched, while the self mode bit is written whatever the strobes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_compare_q       <= `FRWP_RST_BYTE;
            end_address_compare_q <= `FRWP_RST_BYTE;
            program_byte_buffer_q <= `FRWP_RST_BYTE;
            self_mode_q           <= 1'b0;
        end else if (wr) begin
            if (paddr == `FRWP_ADDR_BLOCK_CMP) begin
                block_compare_q <= lane_merge(block_compare_q, pwdata[7:0], pstrb[0]);
            end else if (paddr == `FRWP_ADDR_END_CMP) begin
                end_address_compare_q <= lane_merge(end_address_compare_q,
                                                    pwdata[7:0], pstrb[0]);
            end else if (paddr == `FRWP_ADDR_PROG_BUF) begin
                program_byte_buffer_q <= lane_merge(program_byte_buffer_q,
                                                    pwdata[7:0], pstrb[0]);
            end else if (paddr == `FRWP_ADDR_CTRL) begin
                self_mode_q <= pwdata[`FRWP_CTRL_SELF_BIT];
            end
        end
    end

    // error flag: set wins over software clear
    // a start refused for a shielded block and a walk into a shielded block both set it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wepr_err_q <= 1'b0;
        end else if (state_q == ST_RUN && start == 1'b0 && blk_prot) begin
            wepr_err_q <= 1'b1;
        end else if (start && blk_prot && state_q == ST_IDLE) begin
            wepr_err_q <= 1'b1;
        end else if (wr && hit_stat &&
                     !pwdata[`FRWP_STAT_WEPR_BIT]) begin
            wepr_err_q <= 1'b0;
        end
    end

    // sequencer state
    // load fetches the protect byte; start walks only in self mode and
    // only when the target block is not shielded
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (load) state_d = ST_LOAD;
                else if (start && self_mode_q && !blk_prot) state_d = ST_RUN;
            end
            ST_LOAD: begin
                state_d = ST_IDLE;
            end
            ST_RUN: begin
                if (at_end) state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // pointers, protect byte capture, flash strobes
    // flash read data is taken at the edge that ends the read pulse
    // pointers stop at the compare values, so reload before each command
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q               <= ST_IDLE;
            busy_q                <= 1'b0;
            block_pointer_q       <= `FRWP_RST_BYTE;
            low_address_pointer_q <= `FRWP_RST_BYTE;
            protect_byte_q        <= `FRWP_RST_PROTECT;
            flash_addr            <= 16'h0000;
            flash_rd              <= 1'b0;
            flash_step            <= 1'b0;
            flash_wdata           <= 8'h00;
        end else begin
            state_q     <= state_d;
            busy_q      <= state_d == ST_RUN;
            flash_rd    <= 1'b0;
            flash_step  <= 1'b0;
            flash_wdata <= program_byte_buffer_q;
            if (wr && hit_ptr) begin
                if (pstrb[0]) low_address_pointer_q <= pwdata[7:0];
                if (pstrb[1]) block_pointer_q <= pwdata[15:8];
            end
            if (state_q == ST_IDLE && load) begin
                flash_addr <= `FRWP_PROTECT_ADDR;
                flash_rd   <= 1'b1;
            end else if (state_q == ST_LOAD) begin
                protect_byte_q <= flash_rdata;
            end else if (state_q == ST_RUN) begin
                flash_addr <= {block_pointer_q, low_address_pointer_q};
                flash_step <= 1'b1;
                if (!at_end) begin
                    // pointer walks toward the compare value
                    if (low_address_pointer_q == 8'hFF)
                        block_pointer_q <= block_pointer_q + 8'h01;
                    low_address_pointer_q <= low_address_pointer_q + 8'h01;
                end
            end
        end
    end

endmodule // frwp_top

/* verif/frwp_top_sva.sv */
`timescale 1ns/1ps
// port-level checks of bus answers and sequencer outputs
module frwp_top_sva #(
    parameter NBLK = 16
) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [15:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [15:0] flash_addr,
    input logic        flash_rd,
    input logic [7:0]  flash_rdata,
    input logic        flash_step,
    input logic [7:0]  flash_wdata
);
    logic map_ok;
    logic buf_wr_q;
    logic buf_wr2_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded register window
    assign map_ok = paddr inside {16'hFFA6, 16'hFFA7, 16'hFFA8, 16'hFFAC, 16'hFFB0, 16'hFFB4};
    // remember buffer writes for two cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_wr_q  <= 1'b0;
            buf_wr2_q <= 1'b0;
        end else begin
            buf_wr_q  <= psel && penable && pready && pwrite && pstrb[0] && paddr == 16'hFFA8;
            buf_wr2_q <= buf_wr_q;
        end
    end
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (psel && penable && pready |-> pslverr == !map_ok)
        else $error("error flag does not match decode");
    a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returns data");
    a_prot_addr: assert property (flash_rd |-> flash_addr == 16'h0081)
        else $error("protect byte read at wrong address");
    a_rd_pulse: assert property (flash_rd |=> !flash_rd)
        else $error("protect read longer than one cycle");
    a_step_incr: assert property (flash_step && $past(flash_step) |->
        flash_addr == $past(flash_addr) + 16'h0001) else $error("walk address not incrementing");
    a_wdata_cause: assert property ($changed(flash_wdata) |-> buf_wr_q || buf_wr2_q)
        else $error("program byte changed without a write");
    cover property (flash_step);
    cover property (pslverr);
    cover property (flash_rd);
endmodule // frwp_top_sva

/* verif/frwp_bench.sv */
`timescale 1ns/1ps
`include "frwp_defs.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, x); end end
module frwp_bench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [15:0] paddr = 16'h0000, flash_addr;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  flash_rdata = 8'hFF, flash_wdata;
    logic        pready, pslverr, flash_rd, flash_step;
    int          failures = 0, n_tests = 0;
    logic [15:0] ra [3] = '{`FRWP_ADDR_BLOCK_CMP, `FRWP_ADDR_END_CMP, `FRWP_ADDR_PROG_BUF};
    logic [7:0]  rv [3] = '{8'h0F, 8'h5A, 8'hC3};
    // clock
    always #12.5 pclk = ~pclk;
    frwp_top #(.NBLK(16)) frwp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
        .flash_rd(flash_rd), .flash_rdata(flash_rdata), .flash_step(flash_step),
        .flash_wdata(flash_wdata));
    // one bus transfer, result left in d and e
    task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] wd);
        int n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) failures++;
        d = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // load protect byte, walk block from FE to FF, check flag and pointer
    task automatic run(input logic [4:0] code, input logic [3:0] blk, input logic self,
                       input logic err);
        logic [31:0] c;
        c = {29'h0, 1'b1, 1'b0, self};
        flash_rdata <= {1'b1, code, 2'b11};
        xfer(`FRWP_ADDR_CTRL, 1'b1, c);
        xfer(`FRWP_ADDR_STATUS, 1'b1, 32'h0);
        xfer(`FRWP_ADDR_PTR, 1'b1, {20'h0, blk, 8'hFE});
        xfer(`FRWP_ADDR_BLOCK_CMP, 1'b1, {28'h0, blk});
        xfer(`FRWP_ADDR_END_CMP, 1'b1, 32'hFF);
        xfer(`FRWP_ADDR_CTRL, 1'b1, c ^ 32'h6);
        repeat (20) begin
            xfer(`FRWP_ADDR_STATUS, 1'b0, 32'h0);
            if (d[7] !== 1'b1) break;
        end
        `CHK(d[2], err)
        xfer(`FRWP_ADDR_PTR, 1'b0, 32'h0);
        `CHK(d[15:0], ({4'h0, blk, (err || !self) ? 8'hFE : 8'hFF}))
        `CHK(flash_addr, ((err || !self) ? 16'h0081 : {4'h0, blk, 8'hFF}))
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #(25 * 20000);
        failures++;
        summarize;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            xfer(ra[i], 1'b0, 32'h0);
            `CHK(d[7:0], 8'h00)
        end
        $display("test reset done");
        for (int i = 0; i < 3; i++) xfer(ra[i], 1'b1, {24'h0, rv[i]});
        for (int i = 0; i < 3; i++) begin
            xfer(ra[i], 1'b0, 32'h0);
            `CHK(d[7:0], rv[i])
        end
        $display("test rows done");
        pstrb <= 4'h0;
        xfer(ra[2], 1'b1, 32'h77);
        pstrb <= 4'hF;
        xfer(ra[2], 1'b0, 32'h0);
        `CHK(d[7:0], rv[2])
        `CHK(flash_wdata, rv[2])
        xfer(16'hFFA0, 1'b0, 32'h0);
        `CHK(({e, d}), ({1'b1, 32'h0}))
        $display("test refusal done");
        for (int k = 0; k < 8; k++) begin
            run(5'(8 + k), 4'(15 - 2 * k), 1'b1, 1'b1);
            if (k > 0) run(5'(8 + k), 4'(16 - 2 * k), 1'b1, 1'b0);
        end
        run(5'h1F, 4'h0, 1'b1, 1'b0);
        run(5'h00, 4'hF, 1'b1, 1'b1);
        run(5'h08, 4'h3, 1'b0, 1'b0);
        $display("test protect done");
        xfer(ra[0], 1'b1, 32'h5);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(ra[0], 1'b0, 32'h0);
        `CHK(d[7:0], 8'h00)
        xfer(`FRWP_ADDR_CTRL, 1'b0, 32'h0);
        `CHK(d, 32'h0000FF00)
        $display("test mid reset done");
        summarize;
    end
endmodule // frwp_bench
bind frwp_top frwp_top_sva #(.NBLK(NBLK)) frwp_top_sva_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .flash_step(flash_step), .flash_wdata(flash_wdata));
